// File: hdl/lsts_pkg.sv
// Package: command codes, field layout, reset values and carriers of the threshold/status block
package lsts_pkg;
  // Command codes of the register port
  localparam logic [7:0] CMD_HIGH_BOUND = 8'h01;
  localparam logic [7:0] CMD_LOW_BOUND = 8'h02;
  localparam logic [7:0] CMD_POWER_SAVE = 8'h03;
  localparam logic [7:0] CMD_AMBIENT = 8'h04;
  localparam logic [7:0] CMD_BROADBAND = 8'h05;
  localparam logic [7:0] CMD_STATUS = 8'h06;
  // Field positions in the power save register
  localparam int PS_EN_BIT = 0;
  localparam int PS_SEL_LSB = 1;
  localparam int PS_SEL_MSB = 2;
  // Field positions in the status register
  localparam int ST_BELOW_BIT = 15;
  localparam int ST_ABOVE_BIT = 14;
  // Reset values
  localparam logic [15:0] LOW_BOUND_RST = 16'h0000;
  localparam logic [15:0] HIGH_BOUND_RST = 16'hFFFF;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [15:0] READ_ZERO = 16'h0000;
  // Power saving modes, as the select field encodes them
  typedef enum logic [1:0] {
    LSTS_MODE1 = 2'b00,
    LSTS_MODE2 = 2'b01,
    LSTS_MODE3 = 2'b10,
    LSTS_MODE4 = 2'b11
  } lsts_ps_mode_t;
  localparam lsts_ps_mode_t PS_SEL_RST = LSTS_MODE1;
  // One completed measurement from the analog path
  typedef struct packed {
    logic [15:0] light_level;
    logic [15:0] broadband;
  } lsts_meas_t;
  // One register port request
  typedef struct packed {
    logic [7:0] cmd;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } lsts_req_t;
endpackage

// File: hdl/lsts_regs.sv
// Threshold window, power save and result/status registers of the light sensor
// Register port: one-cycle wr and rd strobes qualified by a command code.
// Reads answered on the next edge by rd_valid; rd_data holds until the next read.
// Writes to result and status codes are dropped; write-only codes read zero.
// Measurement port: meas_done marks one finished conversion of both channels.
// Only the ambient channel meets the window; broadband is stored only.
// Crossing flags stick until the host reads the status code.
// A crossing in the cycle of that read survives it, at the cost of
// being reported one read later than it happened.
// Interrupt enable lives in the configuration word outside this block.
// Bounds reset to an open window, so nothing flags before they are written.
// Reset is synchronous; hold it for at least one edge.
module lsts_regs (
  input wire logic clock,
  input wire logic srst,
  input wire lsts_pkg::lsts_req_t req, // Register port request
  output logic [15:0] rd_data, // Read answer
  output logic rd_valid, // One-cycle answer strobe
  input wire logic meas_done, // Measurement completion pulse
  input wire lsts_pkg::lsts_meas_t meas, // Completed measurement
  input wire logic light_irq_enable, // Interrupt function enable
  output lsts_pkg::lsts_ps_mode_t power_save_select, // Selected mode
  output logic power_save_enable, // Power saving on
  output logic below_window_flag, // Low crossing seen
  output logic above_window_flag // High crossing seen
);

  // Stored registers
  logic [15:0] low_bound_reg; // Lower window bound
  logic [15:0] high_bound_reg; // Upper window bound
  logic [15:0] ambient_reg; // Last ambient result
  logic [15:0] broadband_reg; // Last broadband result
  logic [15:0] rd_data_next; // Read mux output
  logic below_hit; // Measurement under low bound
  logic above_hit; // Measurement over high bound
  logic status_rd; // Status register being read

  // Places the two flags in their status word positions
  function automatic logic [15:0] status_word(input logic below, input logic above);
    logic [15:0] w;
    w = lsts_pkg::READ_ZERO; // Reserved bits stay zero
    w[lsts_pkg::ST_BELOW_BIT] = below;
    w[lsts_pkg::ST_ABOVE_BIT] = above;
    return w;
  endfunction

  // Write strobe decode for one command code
  function automatic logic wr_hit(input lsts_pkg::lsts_req_t r, input logic [7:0] code);
    return r.wr && (r.cmd == code);
  endfunction

  // Upper window bound, full 16 bits in one write
  always_ff @(posedge clock) begin
    if (srst) begin
      high_bound_reg <= lsts_pkg::HIGH_BOUND_RST;
    end else if (wr_hit(req, lsts_pkg::CMD_HIGH_BOUND)) begin
      high_bound_reg <= req.wdata;
    end
  end

  // Lower window bound, bytes kept in place
  always_ff @(posedge clock) begin
    if (srst) begin
      low_bound_reg <= lsts_pkg::LOW_BOUND_RST;
    end else if (wr_hit(req, lsts_pkg::CMD_LOW_BOUND)) begin
      low_bound_reg <= req.wdata;
    end
  end

  // Power save control; bits above the select field are dropped
  always_ff @(posedge clock) begin
    if (srst) begin
      power_save_select <= lsts_pkg::PS_SEL_RST;
      power_save_enable <= 1'b0;
    end else if (wr_hit(req, lsts_pkg::CMD_POWER_SAVE)) begin
      // Reserved bits carry no function, so none are stored
      // A stored reserved bit could never be read back, so it would only cost flops
      power_save_select <= lsts_pkg::lsts_ps_mode_t'(
        req.wdata[lsts_pkg::PS_SEL_MSB:lsts_pkg::PS_SEL_LSB]);
      power_save_enable <= req.wdata[lsts_pkg::PS_EN_BIT];
    end
  end

  // Result capture at completion; writes to these codes are ignored
  // Reads never clear results, so a slow host still sees the last conversion
  always_ff @(posedge clock) begin
    if (srst) begin
      ambient_reg <= lsts_pkg::RESULT_RST;
      broadband_reg <= lsts_pkg::RESULT_RST;
    end else if (meas_done) begin
      ambient_reg <= meas.light_level;
      broadband_reg <= meas.broadband;
    end
  end

  // Window compare against the fresh measurement, not the stored one
  // Strict compares: a level equal to a bound is still inside the window
  always_comb begin
    below_hit = meas.light_level < low_bound_reg;
    above_hit = meas.light_level > high_bound_reg;
    status_rd = req.rd && (req.cmd == lsts_pkg::CMD_STATUS);
  end

  // Crossing flags: set only at completion with enable, cleared by status read.
  // A set in the clearing cycle wins, so no crossing is lost.
  always_ff @(posedge clock) begin
    if (srst) begin
      below_window_flag <= 1'b0;
      above_window_flag <= 1'b0;
    end else begin
      // Host writes never reach the flags
      if (meas_done && light_irq_enable && below_hit) begin
        below_window_flag <= 1'b1;
      end else if (status_rd) begin
        below_window_flag <= 1'b0;
      end
      if (meas_done && light_irq_enable && above_hit) begin
        above_window_flag <= 1'b1;
      end else if (status_rd) begin
        above_window_flag <= 1'b0;
      end
    end
  end

  // Read mux; bound and control registers are write only and read zero
  // Unknown codes fall to zero rather than aliasing a real register
  always_comb begin
    case (req.cmd)
      lsts_pkg::CMD_AMBIENT: begin
        rd_data_next = ambient_reg;
      end
      lsts_pkg::CMD_BROADBAND: begin
        rd_data_next = broadband_reg;
      end
      lsts_pkg::CMD_STATUS: begin
        rd_data_next = status_word(below_window_flag, above_window_flag);
      end
      default: begin
        rd_data_next = lsts_pkg::READ_ZERO;
      end
    endcase
  end

  // Registered read answer, one cycle after the strobe
  // Data kept between reads so a late sampler still gets the answer
  always_ff @(posedge clock) begin
    if (srst) begin
      rd_data <= lsts_pkg::READ_ZERO;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= req.rd;
      if (req.rd) begin
        rd_data <= rd_data_next;
      end
    end
  end

  // Checks
  // All properties run on the one clock; all but the reset check stand down while reset is held.
  // Field positions come from the package, not from the read mux above.

  // A write to the low bound code stores the whole word
  a_low_bound_write: assert property (@(posedge clock) disable iff (srst)
    req.wr && req.cmd == lsts_pkg::CMD_LOW_BOUND |=> low_bound_reg == $past(req.wdata))
    else $error("low bound not stored");

  // Low bound only moves on its own write
  a_low_bound_hold: assert property (@(posedge clock) disable iff (srst)
    !(req.wr && req.cmd == lsts_pkg::CMD_LOW_BOUND) |=> $stable(low_bound_reg))
    else $error("low bound changed without write");

  // A write to the high bound code stores the whole word
  a_high_bound_write: assert property (@(posedge clock) disable iff (srst)
    req.wr && req.cmd == lsts_pkg::CMD_HIGH_BOUND |=> high_bound_reg == $past(req.wdata))
    else $error("high bound not stored");

  // High bound only moves on its own write
  a_high_bound_hold: assert property (@(posedge clock) disable iff (srst)
    !(req.wr && req.cmd == lsts_pkg::CMD_HIGH_BOUND) |=> $stable(high_bound_reg))
    else $error("high bound changed without write");

  // Select and enable taken from their own fields
  a_mode_fields: assert property (@(posedge clock) disable iff (srst)
    req.wr && req.cmd == lsts_pkg::CMD_POWER_SAVE
    |=> power_save_select == $past(req.wdata[lsts_pkg::PS_SEL_MSB:lsts_pkg::PS_SEL_LSB])
    && power_save_enable == $past(req.wdata[lsts_pkg::PS_EN_BIT]))
    else $error("power save fields wrong");

  // Power save state only moves on its own write
  a_mode_hold: assert property (@(posedge clock) disable iff (srst)
    !(req.wr && req.cmd == lsts_pkg::CMD_POWER_SAVE) |=> $stable(power_save_enable) && $stable(power_save_select))
    else $error("power save changed without write");

  // Every read strobe is answered on the next edge
  a_read_strobe: assert property (@(posedge clock) disable iff (srst)
    req.rd |=> rd_valid)
    else $error("read not answered");

  // No answer strobe without a read
  a_strobe_single: assert property (@(posedge clock) disable iff (srst)
    !req.rd |=> !rd_valid)
    else $error("answer strobe without read");

  // Ambient read returns the stored result
  a_ambient_read: assert property (@(posedge clock) disable iff (srst)
    req.rd && req.cmd == lsts_pkg::CMD_AMBIENT |=> rd_valid && rd_data == $past(ambient_reg))
    else $error("ambient read wrong");

  // Broadband read returns the stored result
  a_broadband_read: assert property (@(posedge clock) disable iff (srst)
    req.rd && req.cmd == lsts_pkg::CMD_BROADBAND |=> rd_valid && rd_data == $past(broadband_reg))
    else $error("broadband read wrong");

  // Results load whole words at completion
  a_result_load: assert property (@(posedge clock) disable iff (srst)
    meas_done |=> ambient_reg == $past(meas.light_level) && broadband_reg == $past(meas.broadband))
    else $error("results not loaded");

  // Results hold between completions
  a_result_hold: assert property (@(posedge clock) disable iff (srst)
    !meas_done |=> $stable(ambient_reg) && $stable(broadband_reg))
    else $error("results changed without completion");

  // Reserved status bits always read zero
  a_status_zero: assert property (@(posedge clock) disable iff (srst)
    req.rd && req.cmd == lsts_pkg::CMD_STATUS |=> rd_data[lsts_pkg::ST_ABOVE_BIT-1:0] == '0)
    else $error("status reserved bits not zero");

  // Status read shows the flags as they stood when it was taken
  a_status_flags: assert property (@(posedge clock) disable iff (srst)
    status_rd |=> rd_data[lsts_pkg::ST_BELOW_BIT] == $past(below_window_flag)
    && rd_data[lsts_pkg::ST_ABOVE_BIT] == $past(above_window_flag))
    else $error("status flags misplaced");

  // Enabled completion below the window raises the low flag
  a_below_set: assert property (@(posedge clock) disable iff (srst)
    meas_done && light_irq_enable && meas.light_level < low_bound_reg |=> below_window_flag)
    else $error("below flag not set");

  // Enabled completion above the window raises the high flag
  a_above_set: assert property (@(posedge clock) disable iff (srst)
    meas_done && light_irq_enable && meas.light_level > high_bound_reg |=> above_window_flag)
    else $error("above flag not set");

  // Flags only fall through a status read
  a_flag_sticky: assert property (@(posedge clock) disable iff (srst)
    !status_rd |=> !$fell(below_window_flag) && !$fell(above_window_flag))
    else $error("flag fell without status read");

  // No flag rises without an enabled completion
  a_flag_gated: assert property (@(posedge clock) disable iff (srst)
    !(meas_done && light_irq_enable) |=> !$rose(below_window_flag) && !$rose(above_window_flag))
    else $error("flag rose without enabled completion");

  // A completion with the interrupt function off leaves the window unused
  a_gate_level: assert property (@(posedge clock) disable iff (srst)
    meas_done && !light_irq_enable |=> !$rose(below_window_flag) && !$rose(above_window_flag))
    else $error("window used while disabled");

  // Host writes never raise a flag
  a_write_no_flag: assert property (@(posedge clock) disable iff (srst)
    req.wr && !meas_done |=> !$rose(below_window_flag) && !$rose(above_window_flag))
    else $error("write raised a flag");

  // A status read with no crossing clears both flags
  a_read_clears: assert property (@(posedge clock) disable iff (srst)
    req.rd && req.cmd == lsts_pkg::CMD_STATUS && !meas_done |=> !below_window_flag && !above_window_flag)
    else $error("status read did not clear");

  // Reset clears strobe, flags and power saving
  a_reset_clears: assert property (@(posedge clock)
    srst |=> !rd_valid && !below_window_flag && !above_window_flag && !power_save_enable)
    else $error("reset did not clear state");

  // Scenarios worth seeing
  c_below_event: cover property (@(posedge clock) disable iff (srst)
    $rose(below_window_flag) ##[1:20] rd_valid && rd_data[lsts_pkg::ST_BELOW_BIT]);
  c_above_event: cover property (@(posedge clock) disable iff (srst)
    $rose(above_window_flag));
  c_mode4_on: cover property (@(posedge clock) disable iff (srst)
    $rose(power_save_enable) && power_save_select == lsts_pkg::LSTS_MODE4);
  c_set_vs_clear: cover property (@(posedge clock) disable iff (srst)
    status_rd && meas_done && light_irq_enable && below_hit);
  c_above_read: cover property (@(posedge clock) disable iff (srst)
    status_rd && above_window_flag);

endmodule

// File: tb/lsts_host.sv
// Host controller model driving the register port of the threshold block
module lsts_host (
  input wire logic clock,
  output lsts_pkg::lsts_req_t req,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle port at time zero
  initial req = '0;
  // One-cycle write pulse; released data is scrambled so stale values never look valid
  task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
    @(negedge clock);
    req.cmd = cmd;
    req.wdata = data;
    req.wr = 1'b1;
    @(negedge clock);
    req.wr = 1'b0;
    req.wdata = ~data;
  endtask
  // One-cycle read pulse, then a bounded wait for the answer strobe
  task automatic rd(input logic [7:0] cmd, output logic [15:0] data, output logic ok);
    int n;
    @(negedge clock);
    req.cmd = cmd;
    req.rd = 1'b1;
    @(negedge clock);
    req.rd = 1'b0;
    req.cmd = ~cmd;
    ok = 1'b0;
    data = 16'hXXXX;
    for (n = 0; n < 4 && !ok; n++) begin
      // Answer strobe stands one cycle only
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        data = rd_data;
      end else begin
        @(negedge clock);
      end
    end
  endtask
endmodule

// File: tb/test_lsts_regs.sv
// Self-checking bench of the threshold, power save and status registers
module test_lsts_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, srst, meas_done, light_irq_enable, power_save_enable, below_window_flag, above_window_flag;
  logic rd_valid;
  logic [15:0] rd_data;
  lsts_pkg::lsts_req_t req;
  lsts_pkg::lsts_meas_t meas;
  lsts_pkg::lsts_ps_mode_t power_save_select;
  int num_errors = 0;
  int samples_checked = 0;
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  lsts_regs uut (.clock(clock), .srst(srst), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
    .meas_done(meas_done), .meas(meas), .light_irq_enable(light_irq_enable),
    .power_save_select(power_save_select), .power_save_enable(power_save_enable),
    .below_window_flag(below_window_flag), .above_window_flag(above_window_flag));
  lsts_host host (.clock(clock), .req(req), .rd_data(rd_data), .rd_valid(rd_valid));
  // Verdict and end of run
  task automatic end_sim();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Read through the host and compare
  task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    host.rd(cmd, d, ok);
    if (!ok) begin
      num_errors++;
      end_sim();
    end else begin
      chk($sformatf("read %h", cmd), d, exp);
    end
  endtask
  // One completion pulse; inputs scrambled afterwards so only the pulse may load them
  task automatic measure(input logic [15:0] lvl, input logic [15:0] bb);
    @(negedge clock);
    meas = {lvl, bb};
    meas_done = 1'b1;
    @(negedge clock);
    meas_done = 1'b0;
    meas = ~{lvl, bb};
  endtask
  // Compare both crossing flags at the ports
  task automatic flags(input logic [1:0] exp);
    chk("flags", {14'h0, below_window_flag, above_window_flag}, {14'h0, exp});
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    srst = 1'b1;
    meas_done = 1'b0;
    meas = '0;
    light_irq_enable = 1'b0;
    repeat (12) @(negedge clock);
    srst = 1'b0;
    // Reset state: results, status and write-only places read zero
    for (int c = 1; c <= 6; c++) rd_chk(c[7:0], 16'h0000);
    flags(2'b00);
    // Every mode; host keeps the reserved bits at zero
    for (int m = 0; m < 4; m++) begin
      host.wr(lsts_pkg::CMD_POWER_SAVE, {13'h0000, m[1:0], m[0]});
      chk("select", {14'h0, power_save_select}, {14'h0, m[1:0]});
      chk("enable", {15'h0, power_save_enable}, {15'h0, m[0]});
    end
    host.wr(lsts_pkg::CMD_LOW_BOUND, 16'h1234);
    host.wr(lsts_pkg::CMD_HIGH_BOUND, 16'h5678);
    // Disabled: a crossing raises nothing
    measure(16'h0010, 16'h0000);
    flags(2'b00);
    light_irq_enable = 1'b1;
    // A byte-swapped low bound would flag these
    measure(16'h2000, 16'h0000);
    measure(16'h1234, 16'h0000);
    flags(2'b00);
    measure(16'h1233, 16'hA55A);
    flags(2'b10);
    rd_chk(lsts_pkg::CMD_AMBIENT, 16'h1233);
    rd_chk(lsts_pkg::CMD_BROADBAND, 16'hA55A);
    host.wr(lsts_pkg::CMD_STATUS, 16'hFFFF);
    rd_chk(lsts_pkg::CMD_STATUS, 16'h8000);
    rd_chk(lsts_pkg::CMD_STATUS, 16'h0000);
    // A byte-swapped high bound would miss this; equality is no crossing
    measure(16'h5678, 16'h0000);
    flags(2'b00);
    measure(16'h6000, 16'h0000);
    rd_chk(lsts_pkg::CMD_STATUS, 16'h4000);
    flags(2'b00);
    // Crossing in the very cycle of a status read survives the clear
    fork
      rd_chk(lsts_pkg::CMD_STATUS, 16'h0000);
      measure(16'h0001, 16'h0000);
    join
    flags(2'b10);
    // Mid-run reset: power save, flags and low bound fall back
    host.wr(lsts_pkg::CMD_POWER_SAVE, {13'h0000, 2'b11, 1'b1});
    chk("select", {14'h0, power_save_select}, 16'h0003);
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    flags(2'b00);
    chk("select", {14'h0, power_save_select}, 16'h0000);
    chk("enable", {15'h0, power_save_enable}, 16'h0000);
    rd_chk(lsts_pkg::CMD_AMBIENT, 16'h0000);
    // A kept low bound of 1234 would flag a zero level
    measure(16'h0000, 16'h0000);
    flags(2'b00);
    end_sim();
  end
endmodule
